// ===== design/pmtx_map.svh
// Purpose: addresses, reset values, transmit mode and injection codes and symbol codes
// Assumes: 8-bit control port, 5-bit code groups sent as pairs
// Notes: included by the package and by pmtx_top
// Notes on behaviour
// - int_n low when any flag and mask set
// - reset clears whole interrupt mask
// - mask bits 0-3 gate parity, bus, reject, inhibit
// - mask bits 4-7 gate threshold, cond A, B, user
// - injection over transmit mode over request data
// - reset loads Off, smoother on, b7 set
// - smoother and parity check software switchable
// - mode 000 forwards request data unchanged
// - mode 001 sends all-ones idle pairs
// - mode 010 sends quiet, drops transmitter enable
// - mode 100 sends halt then quiet
// - mode 101 sends halt pairs
// - mode 110 sends quiet, transmitter stays enabled
// - modes 011 and 111 send quiet pairs
// - write skips bits differing from compare register
// - injection field; low bit self-clears after one-shot
`ifndef PMTX_MAP_SVH
`define PMTX_MAP_SVH
// register addresses
`define PMTX_ADDR_MASK 5'h03
`define PMTX_ADDR_TSC 5'h04
`define PMTX_ADDR_CMP 5'h1B
// reset values
`define PMTX_MASK_RST 8'h00
`define PMTX_TSC_RST 8'hA2
`define PMTX_CMP_RST 8'hA2
`define PMTX_RD_NONE 8'h00
// transmit mode codes
`define PMTX_TM_PASS 3'h0
`define PMTX_TM_IDLE 3'h1
`define PMTX_TM_OFF 3'h2
`define PMTX_TM_RES3 3'h3
`define PMTX_TM_HALTQ 3'h4
`define PMTX_TM_HALT 3'h5
`define PMTX_TM_QUIET 3'h6
`define PMTX_TM_RES7 3'h7
// injection codes
`define PMTX_IC_ONESHOT 2'h1
// code groups
`define PMTX_SYM_IDLE 5'h1F
`define PMTX_SYM_HALT 5'h04
`define PMTX_SYM_QUIET 5'h00
`endif

// ===== design/pmtx_pkg.sv
// Purpose: shared types of the mask and transmit state block
// Assumes: pmtx_map.svh supplies the numbers
// Notes: field order of pmtx_tsc_t matches bit order D7..D0
`default_nettype none
package pmtx_pkg;
   `include "pmtx_map.svh"
   // transmit state register layout, D7 first
   typedef struct packed {
      logic res;           // reserved b7
      logic parity_on;     // request parity check enable
      logic smoother_on;   // smoother enable
      logic inject_ctl_hi; // injection mode high bit
      logic inject_ctl_lo; // injection mode low bit
      logic [2:0] mode;    // transmit mode field
   } pmtx_tsc_t;
   // control port request
   typedef struct packed {
      logic [4:0] addr;  // register address
      logic [7:0] wdata; // write data
      logic wr;          // write strobe
      logic rd;          // read strobe
   } pmtx_req_t;
   // control port answer
   typedef struct packed {
      logic [7:0] rdata; // read data
      logic valid;       // read data valid pulse
   } pmtx_rsp_t;
endpackage
`default_nettype wire

// ===== design/pmtx_pair_shifter.sv
// Purpose: serialise one symbol pair per frame, msb first
// Assumes: caller holds pair_in and txen_in stable until load
// Notes: load pulses in the last bit cycle of each pair
`default_nettype none
module pmtx_pair_shifter import pmtx_pkg::*; #(
   parameter int SYM_W = 5
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [2*SYM_W-1:0] pair_in,
   input wire logic txen_in,
   output logic load,
   output logic ser_q,
   output logic txen_q
);
   localparam int PW = 2 * SYM_W;
   localparam int CW = $clog2(PW);
   localparam logic [CW-1:0] LAST = CW'(PW - 1);

   // refuse widths the shifter cannot frame
   if (SYM_W < 1) begin : g_chk
      $error("pmtx_pair_shifter: SYM_W must be positive");
   end

   logic [PW-1:0] sh_q, sh_d; // remaining bits of current pair
   logic [CW-1:0] cnt_q, cnt_d; // bit position within pair
   logic ser_d, txen_d;

   assign load = (cnt_q == LAST);

   // next values: take a new pair only on the boundary
   always_comb begin
      sh_d = {sh_q[PW-2:0], 1'b0};
      ser_d = sh_q[PW-1];
      txen_d = txen_q;
      cnt_d = cnt_q + 1'b1;
      if (load) begin
         sh_d = {pair_in[PW-2:0], 1'b0};
         ser_d = pair_in[PW-1];
         txen_d = txen_in;
         cnt_d = '0;
      end
   end

   // registers; first load comes right after reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sh_q <= '0;
         cnt_q <= LAST;
         ser_q <= 1'b0;
         txen_q <= 1'b0;
      end else begin
         sh_q <= sh_d;
         cnt_q <= cnt_d;
         ser_q <= ser_d;
         txen_q <= txen_d;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   pair_period_a: assert property (load |=> !load [*8] ##1 !load ##1 load)
      else $error("pair boundary not every ten bits");
   txen_hold_a: assert property (!load |=> $stable(txen_q))
      else $error("transmitter enable moved inside a pair");
endmodule
`default_nettype wire

// ===== design/pmtx_top.sv
// Purpose: interrupt mask gating and transmit state pair generator
// Assumes: flags, request pair and injection inputs are on clk_sys
// Notes: control port reads answer one cycle after the strobe
`default_nettype none
`include "pmtx_map.svh"
module pmtx_top import pmtx_pkg::*; #(
   parameter int SYM_W = 5
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire pmtx_req_t reg_req,
   output pmtx_rsp_t reg_rsp,
   input wire logic [7:0] interrupt_condition_flags,
   input wire logic [2*SYM_W-1:0] req_pair,
   input wire logic req_parity,
   input wire logic [2*SYM_W-1:0] inject_pair,
   input wire logic inject_valid,
   input wire logic inject_done,
   output logic int_n,
   output logic ser_req_out,
   output logic fiber_tx_enable,
   output logic smoother_on,
   output logic parity_check_on,
   output logic [1:0] inject_ctl,
   output logic pair_taken,
   output logic req_parity_err,
   output logic write_inhibit_event
);
   localparam int PW = 2 * SYM_W;

   // symbol codes are fixed at five bits
   if (SYM_W != 5) begin : g_chk
      $error("pmtx_top: SYM_W must be 5");
   end

   // reset release synchroniser
   logic rst_meta_q, rst_q;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_q <= rst_meta_q;
      end
   end

   // read decode, shared by read path and its check
   function automatic logic [7:0] rd_mux(input logic [4:0] a, input logic [7:0] m,
                                         input logic [7:0] t, input logic [7:0] c);
      unique case (a)
         `PMTX_ADDR_MASK: rd_mux = m;
         `PMTX_ADDR_TSC: rd_mux = t;
         `PMTX_ADDR_CMP: rd_mux = c;
         default: rd_mux = `PMTX_RD_NONE;
      endcase
   endfunction

   // pair produced by a transmit mode
   function automatic logic [PW-1:0] mode_pair(input logic [2:0] m, input logic [PW-1:0] r);
      unique case (m)
         `PMTX_TM_PASS: mode_pair = r;
         `PMTX_TM_IDLE: mode_pair = {`PMTX_SYM_IDLE, `PMTX_SYM_IDLE};
         `PMTX_TM_HALTQ: mode_pair = {`PMTX_SYM_HALT, `PMTX_SYM_QUIET};
         `PMTX_TM_HALT: mode_pair = {`PMTX_SYM_HALT, `PMTX_SYM_HALT};
         // off, quiet and both reserved codes send quiet
         default: mode_pair = {`PMTX_SYM_QUIET, `PMTX_SYM_QUIET};
      endcase
   endfunction

   // register state
   logic [7:0] mask_q, mask_d;  // interrupt_mask
   pmtx_tsc_t tsc_q, tsc_d;     // transmit_state_control
   logic [7:0] cmp_q, cmp_d;    // transmit_state_compare
   pmtx_rsp_t rsp_q, rsp_d;     // read answer
   logic int_n_q, int_n_d;      // gated interrupt, active low
   logic inh_q, inh_d;          // inhibited write pulse
   logic wr_mask, wr_tsc, wr_cmp;
   logic [7:0] wr_ok;           // bits matching their compare bit

   assign wr_mask = reg_req.wr && (reg_req.addr == `PMTX_ADDR_MASK);
   assign wr_tsc = reg_req.wr && (reg_req.addr == `PMTX_ADDR_TSC);
   assign wr_cmp = reg_req.wr && (reg_req.addr == `PMTX_ADDR_CMP);
   assign wr_ok = ~(tsc_q ^ cmp_q);

   // register next values
   always_comb begin
      mask_d = mask_q;
      tsc_d = tsc_q;
      cmp_d = cmp_q;
      inh_d = 1'b0;
      rsp_d.valid = reg_req.rd;
      rsp_d.rdata = rsp_q.rdata;
      // one-shot finished: drop low injection bit
      if (inject_done && ({tsc_q.inject_ctl_hi, tsc_q.inject_ctl_lo} == `PMTX_IC_ONESHOT)) begin
         tsc_d.inject_ctl_lo = 1'b0;
      end
      if (wr_mask) begin
         mask_d = reg_req.wdata;
      end
      if (wr_cmp) begin
         cmp_d = reg_req.wdata;
      end
      // conditional write: only bits equal to compare take new data
      if (wr_tsc) begin
         tsc_d = (tsc_q & ~wr_ok) | (reg_req.wdata & wr_ok);
         inh_d = ~&wr_ok;
      end
      if (reg_req.rd) begin
         rsp_d.rdata = rd_mux(reg_req.addr, mask_q, tsc_q, cmp_q);
      end
      int_n_d = ~|(interrupt_condition_flags & mask_q);
   end

   // register storage
   always_ff @(posedge clk_sys or negedge rst_q) begin
      if (!rst_q) begin
         mask_q <= `PMTX_MASK_RST;
         tsc_q <= `PMTX_TSC_RST;
         cmp_q <= `PMTX_CMP_RST;
         rsp_q <= '0;
         int_n_q <= 1'b1;
         inh_q <= 1'b0;
      end else begin
         mask_q <= mask_d;
         tsc_q <= tsc_d;
         cmp_q <= cmp_d;
         rsp_q <= rsp_d;
         int_n_q <= int_n_d;
         inh_q <= inh_d;
      end
   end

   // transmit pair selection
   logic load;                // pair boundary from shifter
   logic [PW-1:0] pair_sel;   // pair to send next
   logic txen_sel;            // transmitter enable for next pair
   logic en_q;                // goes high one cycle after reset release, marks it for reset checks
   logic sm_q, sm_d, pc_q, pc_d, taken_q, taken_d, perr_q, perr_d;
   logic [1:0] ic_q, ic_d;

   // injection wins over the mode, the mode over request data
   always_comb begin
      pair_sel = inject_valid ? inject_pair : mode_pair(tsc_q.mode, req_pair);
      txen_sel = (tsc_q.mode != `PMTX_TM_OFF);
      sm_d = tsc_q.smoother_on;
      pc_d = tsc_q.parity_on;
      ic_d = {tsc_q.inject_ctl_hi, tsc_q.inject_ctl_lo};
      taken_d = load;
      // odd parity over the pair, checked as it is taken
      perr_d = load && tsc_q.parity_on && !(^{req_pair, req_parity});
   end

   // static output registers
   always_ff @(posedge clk_sys or negedge rst_q) begin
      if (!rst_q) begin
         en_q <= 1'b0;
         sm_q <= 1'b1;
         pc_q <= 1'b0;
         ic_q <= 2'h0;
         taken_q <= 1'b0;
         perr_q <= 1'b0;
      end else begin
         en_q <= 1'b1;
         sm_q <= sm_d;
         pc_q <= pc_d;
         ic_q <= ic_d;
         taken_q <= taken_d;
         perr_q <= perr_d;
      end
   end

   pmtx_pair_shifter #(.SYM_W(SYM_W)) u_shift (
      .clk_sys(clk_sys),
      .rst_n(rst_q),
      .pair_in(pair_sel),
      .txen_in(txen_sel),
      .load(load),
      .ser_q(ser_req_out),
      .txen_q(fiber_tx_enable)
   );

   assign reg_rsp = rsp_q;
   assign int_n = int_n_q;
   assign smoother_on = sm_q;
   assign parity_check_on = pc_q;
   assign inject_ctl = ic_q;
   assign pair_taken = taken_q;
   assign req_parity_err = perr_q;
   assign write_inhibit_event = inh_q;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_q);

   int_gate_a: assert property (|(interrupt_condition_flags & mask_q) |=> !int_n)
      else $error("interrupt not asserted for unmasked flag");
   int_quiet_a: assert property (!(|(interrupt_condition_flags & mask_q)) |=> int_n)
      else $error("interrupt asserted with no unmasked flag");
   int_order_a: assert property (interrupt_condition_flags == 8'h08 && mask_q == 8'hF7
                                 |=> int_n)
      else $error("mask bit 3 does not gate inhibit flag");
   int_hi_order_a: assert property (interrupt_condition_flags == 8'h80 && mask_q[7]
                                    |=> !int_n)
      else $error("mask bit 7 does not gate user flag");
   reset_mask_a: assert property ($rose(en_q) |-> mask_q == `PMTX_MASK_RST
                                  && $past(mask_q) == `PMTX_MASK_RST)
      else $error("mask not clear after reset");
   reset_ctl_a: assert property ($rose(en_q) |-> tsc_q == `PMTX_TSC_RST && sm_q)
      else $error("transmit state reset value wrong");
   idle_pairs_a: assert property (load && !inject_valid && tsc_q.mode == `PMTX_TM_IDLE
                                  |=> ser_req_out [*8])
      else $error("idle pair not all ones");
   quiet_pairs_a: assert property (load && !inject_valid && (tsc_q.mode == `PMTX_TM_OFF
                                   || tsc_q.mode[1:0] == 2'h3 || tsc_q.mode == `PMTX_TM_QUIET)
                                   |=> !ser_req_out [*8])
      else $error("quiet pair not all zeros");
   halt_quiet_a: assert property (load && !inject_valid && tsc_q.mode == `PMTX_TM_HALTQ
                                  |=> !ser_req_out ##1 !ser_req_out ##1 ser_req_out
                                  ##1 !ser_req_out [*7])
      else $error("halt quiet pair wrong");
   halt_pair_a: assert property (load && !inject_valid && tsc_q.mode == `PMTX_TM_HALT
                                 |-> ##8 ser_req_out)
      else $error("second halt symbol missing");
   off_txen_a: assert property (load && tsc_q.mode == `PMTX_TM_OFF |=> !fiber_tx_enable)
      else $error("transmitter enabled in off mode");
   quiet_txen_a: assert property (load && tsc_q.mode == `PMTX_TM_QUIET |=> fiber_tx_enable)
      else $error("transmitter disabled in quiet mode");
   pass_thru_a: assert property (load && !inject_valid && tsc_q.mode == `PMTX_TM_PASS
                                 |=> ser_req_out == $past(req_pair[PW-1]))
      else $error("request data not forwarded");
   inject_first_a: assert property (load && inject_valid
                                    |=> ser_req_out == $past(inject_pair[PW-1]))
      else $error("injected pair lost priority");
   cond_write_a: assert property (wr_tsc |=> ((tsc_q ^ $past(tsc_q))
                                  & $past(tsc_q ^ cmp_q)) == 8'h00)
      else $error("conditional write changed a guarded bit");
   oneshot_clr_a: assert property (inject_done && !wr_tsc && ic_d == `PMTX_IC_ONESHOT
                                   |=> !tsc_q.inject_ctl_lo ##1 ic_q == 2'h0)
      else $error("one-shot bit not cleared");
   read_back_a: assert property (reg_req.rd |=> reg_rsp.valid && reg_rsp.rdata
                                 == rd_mux($past(reg_req.addr), $past(mask_q),
                                 $past(tsc_q), $past(cmp_q)))
      else $error("read answer wrong");

   irq_seen_c: cover property (!int_n);
   idle_sent_c: cover property (load && tsc_q.mode == `PMTX_TM_IDLE);
   inhibited_c: cover property (write_inhibit_event);
   oneshot_c: cover property (inject_done && ic_d == `PMTX_IC_ONESHOT);
endmodule
`default_nettype wire

// ===== testbench/pmtx_fiber_rx.sv
// Purpose: fiber side receiver model, rebuilds each symbol pair sent
// Assumes: start marks the cycle that shows the first bit, msb first
// Notes: last pair and its enable stay until the next full pair
`default_nettype none
module pmtx_fiber_rx (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic start,
   input wire logic ser_in,
   input wire logic txen_in,
   output logic [9:0] pair_q,
   output logic txen_q,
   output logic [15:0] got_q
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] sh_q; // bits gathered so far
   logic [3:0] cnt_q; // bits gathered, A means idle
   logic en_q; // transmitter enable seen at pair start
   // gather ten bits after each start, then publish the pair
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sh_q <= '0;
         cnt_q <= 4'hA;
         en_q <= 1'b0;
         pair_q <= '0;
         txen_q <= 1'b0;
         got_q <= '0;
      end else if (start) begin
         sh_q <= {9'h000, ser_in};
         cnt_q <= 4'h1;
         en_q <= txen_in;
      end else if (cnt_q < 4'hA) begin
         sh_q <= {sh_q[8:0], ser_in};
         cnt_q <= cnt_q + 4'h1;
         // last bit lands: a whole pair is known
         if (cnt_q == 4'h9) begin
            pair_q <= {sh_q[8:0], ser_in};
            txen_q <= en_q;
            got_q <= got_q + 16'h0001;
         end
      end
   end
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Purpose: self-checking bench of the mask and transmit state block
// Assumes: inputs driven at the falling edge, fiber model on the serial side
// Notes: reset first, then mode table, interrupt, injection, parity, compare, one-shot and second reset cases
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module testbench;
   import pmtx_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [7:0] w; logic [9:0] p; logic t;} pmtx_row_t;
   logic clk_sys, rst_n, int_n, ser_req_out, fiber_tx_enable, smoother_on;
   logic parity_check_on, pair_taken, req_parity_err, write_inhibit_event;
   logic req_parity, inject_valid, inject_done, txen, inh_seen, par_seen;
   logic [1:0] inject_ctl;
   logic [7:0] interrupt_condition_flags, d, tsc_cur;
   logic [9:0] req_pair, inject_pair, pair, prev;
   logic [15:0] got;
   pmtx_req_t reg_req;
   pmtx_rsp_t reg_rsp;
   pmtx_row_t rows [8];
   int err_count, compares, cycles, i;
   pmtx_top #(.SYM_W(5)) dut_u (.clk_sys, .rst_n, .reg_req, .reg_rsp,
      .interrupt_condition_flags, .req_pair, .req_parity, .inject_pair, .inject_valid,
      .inject_done, .int_n, .ser_req_out, .fiber_tx_enable, .smoother_on, .parity_check_on,
      .inject_ctl, .pair_taken, .req_parity_err, .write_inhibit_event);
   pmtx_fiber_rx fiber_u (.clk_sys, .rst_n, .start(pair_taken), .ser_in(ser_req_out),
      .txen_in(fiber_tx_enable), .pair_q(pair), .txen_q(txen), .got_q(got));
   // free running clock, 20 ns period
   always #10 clk_sys = ~clk_sys;
   // sticky catchers for one-cycle pulses, plus the hang limit
   always @(posedge clk_sys) begin
      cycles++;
      if (write_inhibit_event === 1'b1) inh_seen = 1'b1;
      if (req_parity_err === 1'b1) par_seen = 1'b1;
      if (cycles == 5000) begin
         err_count++;
         finish_test();
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // one write strobe cycle
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      @(negedge clk_sys);
      reg_req = '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(negedge clk_sys);
      reg_req = '0;
   endtask
   // one read strobe cycle, data taken with the valid pulse
   task automatic rd(input logic [4:0] a, output logic [7:0] v);
      @(negedge clk_sys);
      reg_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(negedge clk_sys);
      reg_req = '0;
      `CHK(reg_rsp.valid, 1'b1)
      v = reg_rsp.rdata;
   endtask
   // load compare with the current value first so no bit is guarded
   task automatic wr_tsc(input logic [7:0] v);
      wr(5'h1B, tsc_cur);
      wr(5'h04, v);
      tsc_cur = v;
   endtask
   // wait for n more whole pairs at the fiber model, bounded
   task automatic pairs(input int n);
      logic [15:0] g0;
      int k;
      g0 = got;
      k = 0;
      while (got != g0 + 16'(n) && k < 40 * n) begin
         @(negedge clk_sys);
         k++;
      end
      `CHK(got, g0 + 16'(n))
   endtask
   task automatic finish_test();
      $display("counts: compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      clk_sys = 1'b0;
      rst_n = 1'b0;
      reg_req = '0;
      interrupt_condition_flags = 8'h00;
      req_pair = 10'h2B5;
      req_parity = ~^10'h2B5;
      inject_pair = 10'h155;
      inject_valid = 1'b0;
      inject_done = 1'b0;
      inh_seen = 1'b0;
      par_seen = 1'b0;
      tsc_cur = 8'hA2;
      rows[0] = '{8'hA0, 10'h2B5, 1'b1};
      rows[1] = '{8'hA1, 10'h3FF, 1'b1};
      rows[2] = '{8'hA2, 10'h000, 1'b0};
      rows[3] = '{8'hA3, 10'h000, 1'b1};
      rows[4] = '{8'hA4, 10'h080, 1'b1};
      rows[5] = '{8'hA5, 10'h084, 1'b1};
      rows[6] = '{8'hA6, 10'h000, 1'b1};
      rows[7] = '{8'hA7, 10'h000, 1'b1};
      cyc(20);
      rst_n = 1'b1;
      cyc(4);
      // reset values at the ports and in the registers
      rd(5'h04, d);
      `CHK(d, 8'hA2)
      rd(5'h03, d);
      `CHK(d, 8'h00)
      `CHK(int_n, 1'b1)
      `CHK({smoother_on, parity_check_on, inject_ctl}, 4'h8)
      `CHK(fiber_tx_enable, 1'b0)
      $display("test reset done");
      // every transmit mode; the first pair after a change is old or new, never mixed
      prev = 10'h000;
      for (i = 0; i < 8; i++) begin
         wr_tsc(rows[i].w);
         pairs(1);
         `CHK(pair === prev || pair === rows[i].p, 1'b1)
         pairs(1);
         `CHK(pair, rows[i].p)
         `CHK(txen, rows[i].t)
         prev = rows[i].p;
      end
      $display("test modes done");
      // each mask bit gates only its own flag
      for (i = 0; i < 8; i++) begin
         wr(5'h03, 8'h01 << i);
         interrupt_condition_flags = 8'h01 << i;
         cyc(2);
         `CHK(int_n, 1'b0)
         interrupt_condition_flags = ~(8'h01 << i);
         cyc(2);
         `CHK(int_n, 1'b1)
      end
      rd(5'h03, d);
      `CHK(d, 8'h80)
      interrupt_condition_flags = 8'h00;
      $display("test interrupt done");
      // injected pair wins over idle mode
      wr_tsc(8'hA1);
      inject_valid = 1'b1;
      pairs(2);
      `CHK(pair, 10'h155)
      inject_valid = 1'b0;
      $display("test injection done");
      // parity check on, smoother off, then a bad parity pair
      wr_tsc(8'hC0);
      cyc(2);
      `CHK({parity_check_on, smoother_on}, 2'h2)
      par_seen = 1'b0;
      req_parity = ^10'h2B5;
      cyc(25);
      `CHK(par_seen, 1'b1)
      req_parity = ~^10'h2B5;
      $display("test parity done");
      // guarded bits 7 and 6 keep their value against a cleared compare
      inh_seen = 1'b0;
      wr(5'h1B, 8'h00);
      wr(5'h04, 8'h25);
      cyc(2);
      rd(5'h04, d);
      `CHK(d, 8'hE5)
      `CHK(inh_seen, 1'b1)
      tsc_cur = 8'hE5;
      $display("test compare done");
      // one-shot request clears its low bit when done
      wr_tsc(8'hA8);
      cyc(2);
      `CHK(inject_ctl, 2'h1)
      inject_done = 1'b1;
      cyc(1);
      inject_done = 1'b0;
      cyc(2);
      `CHK(inject_ctl, 2'h0)
      rd(5'h04, d);
      `CHK(d, 8'hA0)
      $display("test one-shot done");
      // second reset in mid-run must restore mask, transmit state and int_n defaults
      rst_n = 1'b0;
      cyc(3);
      tsc_cur = 8'hA2;
      rst_n = 1'b1;
      cyc(4);
      rd(5'h03, d);
      `CHK(d, 8'h00)
      rd(5'h04, d);
      `CHK(d, 8'hA2)
      `CHK(int_n, 1'b1)
      $display("test second reset done");
      finish_test();
   end
endmodule
`undef CHK
`default_nettype wire
